// ==== hdl/hmac_pkg.sv ====
// package for the memory-mapped multiply-accumulate peripheral
// assumes a 16-bit cpu issuing single-cycle register reads and writes
package hmac_pkg;

    // ======================================================================
    // register offsets (byte addresses on the peripheral port)
    localparam logic [7:0] OFS_UNSIGNED_PRODUCT_ENTRY    = 8'h10;
    localparam logic [7:0] OFS_SIGNED_PRODUCT_ENTRY      = 8'h12;
    localparam logic [7:0] OFS_UNSIGNED_ACCUMULATE_ENTRY = 8'h14;
    localparam logic [7:0] OFS_SIGNED_ACCUMULATE_ENTRY   = 8'h16;
    localparam logic [7:0] OFS_SECOND_OPERAND            = 8'h18;
    localparam logic [7:0] OFS_RESULT_LOW_WORD           = 8'h1a;
    localparam logic [7:0] OFS_RESULT_HIGH_WORD          = 8'h1c;
    localparam logic [7:0] OFS_RESULT_EXTENSION          = 8'h1e;

    // ======================================================================
    // reset values and fixed codes
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [15:0] EXT_NEG    = 16'hffff;
    localparam logic [15:0] EXT_CARRY  = 16'h0001;
    localparam logic [15:0] EXT_NONE   = 16'h0000;
    localparam int          STALL_CYC  = 1;

    // ======================================================================
    // operation chosen by the first-operand address
    typedef enum logic [1:0] {
        HMAC_PROD_U = 2'h0,
        HMAC_PROD_S = 2'h1,
        HMAC_ACC_U  = 2'h2,
        HMAC_ACC_S  = 2'h3
    } hmac_mode_t;

    // sequencer states, one-hot
    typedef enum logic [1:0] {
        HMAC_IDLE = 2'b01,
        HMAC_CALC = 2'b10
    } hmac_state_t;

    // one peripheral access from the cpu
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } hmac_req_t;

    // read answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } hmac_rsp_t;

endpackage : hmac_pkg

// ==== hdl/hmac_top.sv ====
// multiply-accumulate peripheral beside a 16-bit cpu core
// assumes the cpu drives one access per cycle on the same clock and
// honours the stall output before it reads any result register
`timescale 1ns/1ps

module hmac_top (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire hmac_pkg::hmac_req_t bus_req,
    output hmac_pkg::hmac_rsp_t     bus_rsp,
    output logic                    cpu_stall
);

    // ======================================================================
    // decode helpers
    function automatic logic is_entry(input logic [7:0] a);
        return (a == hmac_pkg::OFS_UNSIGNED_PRODUCT_ENTRY) ||
               (a == hmac_pkg::OFS_SIGNED_PRODUCT_ENTRY) ||
               (a == hmac_pkg::OFS_UNSIGNED_ACCUMULATE_ENTRY) ||
               (a == hmac_pkg::OFS_SIGNED_ACCUMULATE_ENTRY);
    endfunction : is_entry

    function automatic hmac_pkg::hmac_mode_t entry_mode(
        input logic [7:0] a);
        unique case (a)
            hmac_pkg::OFS_SIGNED_PRODUCT_ENTRY:
                return hmac_pkg::HMAC_PROD_S;
            hmac_pkg::OFS_UNSIGNED_ACCUMULATE_ENTRY:
                return hmac_pkg::HMAC_ACC_U;
            hmac_pkg::OFS_SIGNED_ACCUMULATE_ENTRY:
                return hmac_pkg::HMAC_ACC_S;
            default:
                return hmac_pkg::HMAC_PROD_U;
        endcase
    endfunction : entry_mode

    // ======================================================================
    // state
    hmac_pkg::hmac_state_t state_q;
    hmac_pkg::hmac_state_t state_d;
    hmac_pkg::hmac_mode_t  mode_q;
    hmac_pkg::hmac_mode_t  mode_d;
    logic [15:0]           first_operand_q;
    logic [15:0]           first_operand_d;
    logic [15:0]           second_operand_q;
    logic [15:0]           second_operand_d;
    logic [15:0]           result_low_word_q;
    logic [15:0]           result_low_word_d;
    logic [15:0]           result_high_word_q;
    logic [15:0]           result_high_word_d;
    logic [15:0]           result_extension_q;
    logic [15:0]           result_extension_d;
    hmac_pkg::hmac_rsp_t   rsp_q;
    hmac_pkg::hmac_rsp_t   rsp_d;

    logic                  entry_wr;
    logic                  launch_wr;
    logic                  signed_op;
    logic                  accum_op;
    logic [31:0]           op1_ext;
    logic [31:0]           op2_ext;
    logic [31:0]           prod_w;
    logic [32:0]           acc_w;
    logic [31:0]           new_sum;
    logic [15:0]           new_ext;

    assign entry_wr  = bus_req.wr && is_entry(bus_req.addr);
    assign launch_wr = bus_req.wr &&
                       (bus_req.addr == hmac_pkg::OFS_SECOND_OPERAND);

    // ======================================================================
    // datapath
    // one 16x16 array serves every operand size: 8-bit operands arrive
    // zero- or sign-extended by the cpu, so no size mode is needed
    assign signed_op = (mode_q == hmac_pkg::HMAC_PROD_S) ||
                       (mode_q == hmac_pkg::HMAC_ACC_S);
    assign accum_op  = (mode_q == hmac_pkg::HMAC_ACC_U) ||
                       (mode_q == hmac_pkg::HMAC_ACC_S);

    // both operands are widened to 32 bits first: the low half of one
    // plain product is then right for signed and unsigned alike, and no
    // tool is left to guess the width of a signed multiply
    always_comb begin
        if (signed_op) begin
            op1_ext = {{16{first_operand_q[15]}}, first_operand_q};
            op2_ext = {{16{second_operand_q[15]}}, second_operand_q};
        end else begin
            op1_ext = {16'h0000, first_operand_q};
            op2_ext = {16'h0000, second_operand_q};
        end
        prod_w = op1_ext * op2_ext;
    end

    // accumulate keeps a carry bit so the unsigned overflow can be shown
    assign acc_w = {1'b0, result_high_word_q, result_low_word_q} +
                   {1'b0, prod_w};

    always_comb begin
        new_sum = accum_op ? acc_w[31:0] : prod_w;
        unique case (mode_q)
            hmac_pkg::HMAC_PROD_U: new_ext = hmac_pkg::EXT_NONE;
            hmac_pkg::HMAC_ACC_U:  new_ext = acc_w[32] ?
                hmac_pkg::EXT_CARRY : hmac_pkg::EXT_NONE;
            default:              new_ext = new_sum[31] ?
                hmac_pkg::EXT_NEG : hmac_pkg::EXT_NONE;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        state_d            = state_q;
        mode_d             = mode_q;
        first_operand_d    = first_operand_q;
        second_operand_d   = second_operand_q;
        result_low_word_d  = result_low_word_q;
        result_high_word_d = result_high_word_q;
        result_extension_d = result_extension_q;
        rsp_d              = '0;

        // the entry address alone selects the operation
        if (entry_wr) begin
            mode_d          = entry_mode(bus_req.addr);
            first_operand_d = bus_req.wdata;
        end
        if (launch_wr) begin
            second_operand_d = bus_req.wdata;
        end
        if (bus_req.wr &&
            bus_req.addr == hmac_pkg::OFS_RESULT_LOW_WORD) begin
            result_low_word_d = bus_req.wdata;
        end
        if (bus_req.wr &&
            bus_req.addr == hmac_pkg::OFS_RESULT_HIGH_WORD) begin
            result_high_word_d = bus_req.wdata;
        end

        unique case (state_q)
            hmac_pkg::HMAC_IDLE: begin
                // operand two write starts the kept operation
                if (launch_wr) begin
                    state_d = hmac_pkg::HMAC_CALC;
                end
            end
            hmac_pkg::HMAC_CALC: begin
                // result update wins over a stray software write
                result_low_word_d  = new_sum[15:0];
                result_high_word_d = new_sum[31:16];
                result_extension_d = new_ext;
                state_d            = hmac_pkg::HMAC_IDLE;
            end
            default: begin
                state_d = hmac_pkg::HMAC_IDLE;
            end
        endcase

        // reads answer one cycle later from registered data
        if (bus_req.rd) begin
            rsp_d.valid = 1'b1;
            unique case (bus_req.addr)
                hmac_pkg::OFS_UNSIGNED_PRODUCT_ENTRY,
                hmac_pkg::OFS_SIGNED_PRODUCT_ENTRY,
                hmac_pkg::OFS_UNSIGNED_ACCUMULATE_ENTRY,
                hmac_pkg::OFS_SIGNED_ACCUMULATE_ENTRY:
                    rsp_d.data = first_operand_q;
                hmac_pkg::OFS_SECOND_OPERAND:
                    rsp_d.data = second_operand_q;
                hmac_pkg::OFS_RESULT_LOW_WORD:
                    rsp_d.data = result_low_word_q;
                hmac_pkg::OFS_RESULT_HIGH_WORD:
                    rsp_d.data = result_high_word_q;
                hmac_pkg::OFS_RESULT_EXTENSION:
                    rsp_d.data = result_extension_q;
                default:
                    rsp_d.data = hmac_pkg::RST_WORD;
            endcase
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q            <= hmac_pkg::HMAC_IDLE;
            mode_q             <= hmac_pkg::HMAC_PROD_U;
            first_operand_q    <= hmac_pkg::RST_WORD;
            second_operand_q   <= hmac_pkg::RST_WORD;
            result_low_word_q  <= hmac_pkg::RST_WORD;
            result_high_word_q <= hmac_pkg::RST_WORD;
            result_extension_q <= hmac_pkg::RST_WORD;
            rsp_q              <= '0;
        end else begin
            state_q            <= state_d;
            mode_q             <= mode_d;
            first_operand_q    <= first_operand_d;
            second_operand_q   <= second_operand_d;
            result_low_word_q  <= result_low_word_d;
            result_high_word_q <= result_high_word_d;
            result_extension_q <= result_extension_d;
            rsp_q              <= rsp_d;
        end
    end

    // besides the read answer on bus_rsp, the stall is the only way the unit touches the cpu
    assign cpu_stall = (state_q == hmac_pkg::HMAC_CALC);
    assign bus_rsp   = rsp_q;

    // ======================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    mode_select_a: assert property (
        entry_wr && bus_req.addr == hmac_pkg::OFS_SIGNED_ACCUMULATE_ENTRY
        |=> mode_q == hmac_pkg::HMAC_ACC_S)
        else $error("entry address did not select signed accumulate");

    unsigned_prod_a: assert property (
        cpu_stall && mode_q == hmac_pkg::HMAC_PROD_U
        |=> {result_high_word_q, result_low_word_q} ==
            {16'h0000, $past(first_operand_q)} *
            {16'h0000, $past(second_operand_q)})
        else $error("unsigned product wrong");

    byte_size_a: assert property (
        cpu_stall && !signed_op && !accum_op &&
        first_operand_q[15:8] == 8'h00 && second_operand_q[15:8] == 8'h00
        |=> result_high_word_q == 16'h0000)
        else $error("8x8 unsigned product overflowed the low word");

    op_hold_a: assert property (
        launch_wr && !entry_wr
        |=> second_operand_q == $past(bus_req.wdata) &&
            $stable(first_operand_q))
        else $error("operand registers not held separately");

    low_read_a: assert property (
        bus_req.rd && bus_req.addr == hmac_pkg::OFS_RESULT_LOW_WORD
        |=> bus_rsp.valid && bus_rsp.data == $past(result_low_word_q))
        else $error("low result read wrong");

    high_read_a: assert property (
        bus_req.rd && bus_req.addr == hmac_pkg::OFS_RESULT_HIGH_WORD
        |=> bus_rsp.data == $past(result_high_word_q))
        else $error("high result read wrong");

    ext_sign_a: assert property (
        cpu_stall && mode_q == hmac_pkg::HMAC_PROD_S
        |=> result_extension_q ==
            (result_high_word_q[15] ? hmac_pkg::EXT_NEG : hmac_pkg::EXT_NONE))
        else $error("extension does not follow product sign");

    stall_one_a: assert property (
        launch_wr && !cpu_stall |=> cpu_stall ##1 !cpu_stall)
        else $error("stall not exactly one cycle");

    quiet_cpu_a: assert property (
        !launch_wr |=> !cpu_stall)
        else $error("stall without a launch");

    launch_kept_a: assert property (
        launch_wr && !entry_wr && !cpu_stall
        |=> $stable(mode_q) && $stable(first_operand_q))
        else $error("launch disturbed the kept operation");

    accum_add_a: assert property (
        cpu_stall && mode_q == hmac_pkg::HMAC_ACC_U
        |=> {result_high_word_q, result_low_word_q} ==
            $past({result_high_word_q, result_low_word_q}) +
            {16'h0000, $past(first_operand_q)} *
            {16'h0000, $past(second_operand_q)})
        else $error("accumulate did not add to previous result");

    ext_read_only_a: assert property (
        bus_req.wr && bus_req.addr == hmac_pkg::OFS_RESULT_EXTENSION &&
        !cpu_stall
        |=> $stable(result_extension_q))
        else $error("software write reached the extension register");

    acc_run_c: cover property (
        entry_wr && bus_req.addr == hmac_pkg::OFS_UNSIGNED_ACCUMULATE_ENTRY
        ##2 launch_wr ##1 cpu_stall);
    acc_neg_c: cover property (
        cpu_stall && mode_q == hmac_pkg::HMAC_ACC_S ##1
        result_extension_q == hmac_pkg::EXT_NEG);
    carry_c: cover property (
        cpu_stall && mode_q == hmac_pkg::HMAC_ACC_U && acc_w[32]);
    back_to_back_c: cover property (
        cpu_stall ##2 launch_wr ##1 cpu_stall);
    signed_neg_c: cover property (
        cpu_stall && mode_q == hmac_pkg::HMAC_PROD_S && prod_w[31]);

endmodule : hmac_top

// ==== tb/hmac_cpu_model.sv ====
// cpu-side partner: issues peripheral reads and writes
// assumes the multiplier samples requests on the rising ref_clk edge
`timescale 1ns/1ps

module hmac_cpu_model (
    input  wire logic                ref_clk,
    input  wire hmac_pkg::hmac_rsp_t bus_rsp,
    input  wire logic                cpu_stall,
    output hmac_pkg::hmac_req_t      bus_req
);
    int stall_seen;

    initial begin
        bus_req = '0;
        stall_seen = 0;
    end

    // ======================================================================
    // bus cycles, launched just after a falling edge
    // idle lines flip so that a stale address or data never looks valid
    task automatic idle();
        bus_req.wr = 1'b0;
        bus_req.rd = 1'b0;
        bus_req.addr = ~bus_req.addr;
        bus_req.wdata = ~bus_req.wdata;
    endtask : idle

    task automatic write(input logic [7:0] a, input logic [15:0] d);
        int n;
        @(negedge ref_clk);
        bus_req = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        idle();
        n = 0;
        stall_seen = 0;
        // results are not touched while the stall stands
        while (cpu_stall === 1'b1 && n < 8) begin
            stall_seen++;
            n++;
            @(negedge ref_clk);
        end
    endtask : write

    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        bus_req = '{1'b0, 1'b1, a, bus_req.wdata};
        @(negedge ref_clk);
        idle();
        d = (bus_rsp.valid === 1'b1) ? bus_rsp.data : 16'hxxxx;
    endtask : read

    // misbehaving cpu: reads while the stall still stands
    task automatic peek_in_stall(input logic [7:0] a, input logic [15:0] b,
                                 output logic [15:0] d);
        @(negedge ref_clk);
        bus_req = '{1'b1, 1'b0, hmac_pkg::OFS_SECOND_OPERAND, b};
        @(negedge ref_clk);
        bus_req = '{1'b0, 1'b1, a, ~b};
        stall_seen = (cpu_stall === 1'b1) ? 1 : 0;
        @(negedge ref_clk);
        idle();
        d = (bus_rsp.valid === 1'b1) ? bus_rsp.data : 16'hxxxx;
    endtask : peek_in_stall
endmodule : hmac_cpu_model

// ==== tb/hw_multiply_accumulate_test.sv ====
// self-checking bench for the multiply-accumulate peripheral
// assumes hmac_top and hmac_cpu_model are compiled beforehand
`timescale 1ns/1ps

module hw_multiply_accumulate_test;
    typedef struct packed {
        logic [7:0]  entry;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic [31:0] prod;
        logic [15:0] ext;
    } hmac_row_t;

    localparam int MAX_CYC = 2000;

    logic                ref_clk;
    logic                reset;
    hmac_pkg::hmac_req_t bus_req;
    hmac_pkg::hmac_rsp_t bus_rsp;
    logic                cpu_stall;
    int                  err_count;
    int                  n_checks;
    int                  cyc;

    // every entry and every operand width, each accumulate row builds on the last
    hmac_row_t rows [8] = '{
        '{8'h10, 16'hffff, 16'hffff, 32'hfffe0001, 16'h0000},
        '{8'h12, 16'hffff, 16'h0002, 32'hfffffffe, 16'hffff},
        '{8'h14, 16'h00ff, 16'h00ff, 32'h0000fdff, 16'h0001},
        '{8'h16, 16'hff80, 16'h0100, 32'h00007dff, 16'h0000},
        '{8'h10, 16'h1234, 16'h0010, 32'h00012340, 16'h0000},
        '{8'h12, 16'h7fff, 16'h8000, 32'hc0008000, 16'hffff},
        '{8'h16, 16'h0003, 16'hfffd, 32'hc0007ff7, 16'hffff},
        '{8'h14, 16'h0001, 16'h0001, 32'hc0007ff8, 16'h0000}
    };

    hmac_top uut (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .bus_req   (bus_req),
        .bus_rsp   (bus_rsp),
        .cpu_stall (cpu_stall)
    );

    hmac_cpu_model cpu (
        .ref_clk   (ref_clk),
        .bus_rsp   (bus_rsp),
        .cpu_stall (cpu_stall),
        .bus_req   (bus_req)
    );

    // ======================================================================
    // clock, timeout and reporting
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic results(output logic [15:0] lo, hi, ex);
        cpu.read(hmac_pkg::OFS_RESULT_LOW_WORD, lo);
        cpu.read(hmac_pkg::OFS_RESULT_HIGH_WORD, hi);
        cpu.read(hmac_pkg::OFS_RESULT_EXTENSION, ex);
    endtask : results

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            err_count++;
            close_out();
        end
    end

    // ======================================================================
    // main sequence
    initial begin
        logic [15:0] lo, hi, ex, d;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) begin
            cpu.read(8'h10 + 8'(2 * i), d);
            check(d, 16'h0000, "reset value");
        end
        foreach (rows[i]) begin
            cpu.write(rows[i].entry, rows[i].op_a);
            cpu.write(hmac_pkg::OFS_SECOND_OPERAND, rows[i].op_b);
            check(16'(cpu.stall_seen), 16'h0001, "stall length");
            results(lo, hi, ex);
            check(lo, rows[i].prod[15:0], "low word");
            check(hi, rows[i].prod[31:16], "high word");
            check(ex, rows[i].ext, "extension");
        end
        cpu.read(8'h14, d);
        check(d, 16'h0001, "first operand kept");
        // second launch reuses kept operand and accumulate mode
        cpu.write(hmac_pkg::OFS_SECOND_OPERAND, 16'h0002);
        cpu.read(hmac_pkg::OFS_SECOND_OPERAND, d);
        check(d, 16'h0002, "second operand kept");
        results(lo, hi, ex);
        check(lo, 16'h7ffa, "relaunch low");
        check(hi, 16'hc000, "relaunch high");
        // preloaded sum wraps with carry
        cpu.write(hmac_pkg::OFS_RESULT_LOW_WORD, 16'hffff);
        cpu.write(hmac_pkg::OFS_RESULT_HIGH_WORD, 16'hffff);
        cpu.write(hmac_pkg::OFS_SECOND_OPERAND, 16'h0001);
        cpu.write(hmac_pkg::OFS_RESULT_EXTENSION, 16'h5555);
        results(lo, hi, ex);
        check({lo | hi}, 16'h0000, "wrapped sum");
        check(ex, 16'h0001, "carry kept");
        cpu.read(8'h20, d);
        check(d, 16'h0000, "unmapped read");
        // read inside the stall still shows the old result
        cpu.write(hmac_pkg::OFS_UNSIGNED_PRODUCT_ENTRY, 16'h0003);
        cpu.peek_in_stall(hmac_pkg::OFS_RESULT_LOW_WORD, 16'h0005, d);
        check(d, 16'h0000, "read during stall");
        check(16'(cpu.stall_seen), 16'h0001, "stall raised");
        cpu.read(hmac_pkg::OFS_RESULT_LOW_WORD, d);
        check(d, 16'h000f, "after stall");
        // second reset mid-run must bring back plain multiply
        @(negedge ref_clk);
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        cpu.read(hmac_pkg::OFS_UNSIGNED_ACCUMULATE_ENTRY, d);
        check(d, 16'h0000, "operand after reset");
        cpu.write(hmac_pkg::OFS_RESULT_LOW_WORD, 16'h0007);
        cpu.write(hmac_pkg::OFS_SECOND_OPERAND, 16'h0002);
        cpu.read(hmac_pkg::OFS_RESULT_LOW_WORD, d);
        check(d, 16'h0000, "mode after reset");
        close_out();
    end
endmodule : hw_multiply_accumulate_test
